// file: src/gpm_pin_mux.sv
// Pin-function multiplexer for shared gpio2 pins, modem-control pins and power-on straps.
// Assumes srst is the power-on reset, external pins are asynchronous, and the keyboard
// controller, IR engines and power-management logic sit on mclk.

// Functional notes
// - pin 70 by sel_b[4:3]: interrupt/gpio1/kbc16
// - legacy mode: pm event drives interrupt low
// - pin 72 by sel_b[5]: panel out/gpio2
// - pin 73 by sel_b[7:6]: panel in/gpio3
// - pin 40 by sel_a[5:4]: cir/gpio4/kbc13
// - pin 39 by sel_a[3:2]: fir/irsel/gpio5
// - pin 69 gpio0, alternate keyboard reset
// - clear-to-send readable at handshake bit 4
// - request-to-send driven low when ready
// - terminal-ready driven low when ready
// - rts A strap latches config port bit
// - dtr A strap latches clear-defaults bit
// - sout A strap latches keyboard enable
// - sout B strap latches clock bit
// - clock bit picks 24 or 48 MHz
module gpm_pin_mux
    import gpm_pkg::*;
(
    // Clock and power-on reset
    input  wire logic              mclk,
    input  wire logic              srst,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata_q,
    // Shared pins 69, 70, 72, 73, 40, 39
    input  wire logic [5:0]        mux_pin_in,
    output logic      [5:0]        mux_pin_out_q,
    output logic      [5:0]        mux_pin_oe_q,
    // UART pins: rts A, dtr A, sout A, sout B, rts B, dtr B
    input  wire logic [3:0]        strap_pin_in,
    output logic      [5:0]        uart_pin_out_q,
    output logic      [5:0]        uart_pin_oe_q,
    output logic      [3:0]        strap_pulldown_q,
    // Modem inputs, index 0 is UART A
    input  wire logic [1:0]        clear_to_send_n,
    input  wire logic [1:0]        data_set_ready_n,
    input  wire logic [1:0]        carrier_detect_n,
    input  wire logic [1:0]        ring_indicator_n,
    // UART core serial data
    input  wire logic [1:0]        uart_serial_out,
    // Keyboard controller ports p13 p14 p15 p16 p20 p21
    input  wire logic [5:0]        kbd_ctrl_port_drive,
    output logic      [5:0]        kbd_ctrl_port_sense_q,
    // Other on-chip functions
    input  wire logic              pm_event,
    input  wire logic              panel_switch_output,
    input  wire logic              ir_module_select0,
    output logic                   consumer_ir_receive_q,
    output logic                   fast_ir_receive_q,
    output logic                   panel_switch_input_q,
    // Latched configuration
    output logic                   config_port_addr_q,
    output logic                   clear_defaults_q,
    output logic                   kbd_enable_bit_q,
    output logic                   clock_rate_bit_q
);

    logic [7:0] pin_sel_a_q;
    logic [7:0] pin_sel_b_q;
    logic [7:0] strap_cfg_q;
    logic [7:0] cfg_port_q;
    logic [7:0] modem_ctl_a_q;
    logic [7:0] modem_ctl_b_q;
    logic [7:0] pm_ctl_q;
    logic [5:0] gpio2_data_q;
    logic [5:0] gpio2_dir_q;
    logic [5:0] gpio2_alt_q;

    logic [5:0] mux_s;
    logic [3:0] strap_s;
    logic [1:0] cts_s;
    logic [1:0] dsr_s;
    logic [1:0] dcd_s;
    logic [1:0] ri_s;

    logic [5:0] alt_src;
    logic [5:0] gp_out;
    logic [5:0] gp_oe;
    logic [5:0] mux_out_d;
    logic [5:0] mux_oe_d;
    logic [5:0] kbc_sense_d;
    logic       cir_d;
    logic       fir_d;
    logic       panel_in_d;
    logic       smi_active;
    logic [1:0] sel70;
    logic [1:0] sel73;
    logic [1:0] sel40;
    logic [1:0] sel39;
    logic [7:0] rdata_d;

    // Every pin level from outside passes two flops
    gpm_sync_if #(.W(SYNC_W)) sync_bus (.clk(mclk));

    assign sync_bus.raw = {ring_indicator_n, carrier_detect_n, data_set_ready_n,
                           clear_to_send_n, strap_pin_in, mux_pin_in};

    gpm_sync u_sync (
        .sif (sync_bus.syn)
    );

    assign mux_s   = sync_bus.synced[5:0];
    assign strap_s = sync_bus.synced[9:6];
    assign cts_s   = sync_bus.synced[11:10];
    assign dsr_s   = sync_bus.synced[13:12];
    assign dcd_s   = sync_bus.synced[15:14];
    assign ri_s    = sync_bus.synced[17:16];

    assign sel70 = pin_sel_b_q[FLD_P70_LO +: 2];
    assign sel73 = pin_sel_b_q[FLD_P73_LO +: 2];
    assign sel40 = pin_sel_a_q[FLD_P40_LO +: 2];
    assign sel39 = pin_sel_a_q[FLD_P39_LO +: 2];

    // Alternate source per gpio2 bit: p20 p13 p14 p15 p16 p21
    assign alt_src = {kbd_ctrl_port_drive[KP21], kbd_ctrl_port_drive[KP16], kbd_ctrl_port_drive[KP15],
                      kbd_ctrl_port_drive[KP14], kbd_ctrl_port_drive[KP13], kbd_ctrl_port_drive[KP20]};
    // Keyboard port bits are quasi-bidirectional: pull low for 0, release for 1
    assign gp_out = gpio2_data_q & ~gpio2_alt_q;
    assign gp_oe  = (gpio2_alt_q & ~alt_src) | (~gpio2_alt_q & gpio2_dir_q);

    assign smi_active = pm_ctl_q[PM_LEGACY] & pm_event;

    // Pin function selection
    always_comb
    begin
        mux_out_d   = gp_out;
        mux_oe_d    = gp_oe;
        kbc_sense_d = 6'h3f;
        cir_d       = 1'b1;
        fir_d       = 1'b1;
        panel_in_d  = 1'b1;
        // Pin 69 is always gpio2 bit 0; its alternate is keyboard reset
        if (gpio2_alt_q[PIN69])
            kbc_sense_d[KP20] = mux_s[PIN69];
        unique case (sel70)
            SEL_00:
            begin
                mux_out_d[PIN70] = 1'b0;
                mux_oe_d[PIN70]  = smi_active;
            end
            SEL_01:
            begin
                if (gpio2_alt_q[PIN70])
                    kbc_sense_d[KP13] = mux_s[PIN70];
            end
            SEL_10:
            begin
                mux_out_d[PIN70]  = 1'b0;
                mux_oe_d[PIN70]   = ~kbd_ctrl_port_drive[KP16];
                kbc_sense_d[KP16] = mux_s[PIN70];
            end
            default:
            begin
                mux_out_d[PIN70] = 1'b0;
                mux_oe_d[PIN70]  = 1'b0;
            end
        endcase
        if (!pin_sel_b_q[FLD_P72])
        begin
            mux_out_d[PIN72] = 1'b0;
            mux_oe_d[PIN72]  = panel_switch_output;
        end
        else if (gpio2_alt_q[PIN72])
            kbc_sense_d[KP14] = mux_s[PIN72];
        unique case (sel73)
            SEL_00:
            begin
                mux_out_d[PIN73] = 1'b0;
                mux_oe_d[PIN73]  = 1'b0;
                panel_in_d       = mux_s[PIN73];
            end
            SEL_01:
            begin
                if (gpio2_alt_q[PIN73])
                    kbc_sense_d[KP15] = mux_s[PIN73];
            end
            default:
            begin
                mux_out_d[PIN73] = 1'b0;
                mux_oe_d[PIN73]  = 1'b0;
            end
        endcase
        unique case (sel40)
            SEL_00:
            begin
                mux_out_d[PIN40] = 1'b0;
                mux_oe_d[PIN40]  = 1'b0;
                cir_d            = mux_s[PIN40];
            end
            SEL_01:
            begin
                if (gpio2_alt_q[PIN40])
                    kbc_sense_d[KP16] = kbc_sense_d[KP16] & mux_s[PIN40];
            end
            SEL_10:
            begin
                mux_out_d[PIN40]  = 1'b0;
                mux_oe_d[PIN40]   = ~kbd_ctrl_port_drive[KP13];
                kbc_sense_d[KP13] = kbc_sense_d[KP13] & mux_s[PIN40];
            end
            default:
            begin
                mux_out_d[PIN40] = 1'b0;
                mux_oe_d[PIN40]  = 1'b0;
            end
        endcase
        unique case (sel39)
            SEL_00:
            begin
                mux_out_d[PIN39] = 1'b0;
                mux_oe_d[PIN39]  = 1'b0;
                fir_d            = mux_s[PIN39];
            end
            SEL_01:
            begin
                mux_out_d[PIN39] = ir_module_select0;
                mux_oe_d[PIN39]  = 1'b1;
            end
            SEL_10:
            begin
                if (gpio2_alt_q[PIN39])
                    kbc_sense_d[KP21] = mux_s[PIN39];
            end
            default:
            begin
                mux_out_d[PIN39] = 1'b0;
                mux_oe_d[PIN39]  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            mux_pin_out_q         <= 6'h00;
            mux_pin_oe_q          <= 6'h00;
            kbd_ctrl_port_sense_q <= 6'h3f;
            consumer_ir_receive_q <= 1'b1;
            fast_ir_receive_q     <= 1'b1;
            panel_switch_input_q  <= 1'b1;
        end
        else
        begin
            mux_pin_out_q         <= mux_out_d;
            mux_pin_oe_q          <= mux_oe_d;
            kbd_ctrl_port_sense_q <= kbc_sense_d;
            consumer_ir_receive_q <= cir_d;
            fast_ir_receive_q     <= fir_d;
            panel_switch_input_q  <= panel_in_d;
        end
    end

    // Modem-control and serial outputs; strap pins float under reset for the pull-downs
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            uart_pin_out_q   <= 6'h3f;
            uart_pin_oe_q    <= 6'h30;
            strap_pulldown_q <= 4'hf;
        end
        else
        begin
            uart_pin_out_q[UP_RTS_A]  <= ~modem_ctl_a_q[MCTL_RTS];
            uart_pin_out_q[UP_DTR_A]  <= ~modem_ctl_a_q[MCTL_DTR];
            uart_pin_out_q[UP_SOUT_A] <= uart_serial_out[0];
            uart_pin_out_q[UP_SOUT_B] <= uart_serial_out[1];
            uart_pin_out_q[UP_RTS_B]  <= ~modem_ctl_b_q[MCTL_RTS];
            uart_pin_out_q[UP_DTR_B]  <= ~modem_ctl_b_q[MCTL_DTR];
            uart_pin_oe_q             <= 6'h3f;
            strap_pulldown_q          <= 4'h0;
        end
    end

    // Straps are caught every cycle of reset; the last sample before release stays
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cfg_port_q                     <= 8'h00;
            cfg_port_q[BIT_CFG_PORT_ADDR]  <= strap_s[UP_RTS_A];
            strap_cfg_q                    <= 8'h00;
            strap_cfg_q[BIT_CLEAR_DEFAULTS] <= strap_s[UP_DTR_A];
            strap_cfg_q[BIT_KBD_ENABLE]    <= strap_s[UP_SOUT_A];
            strap_cfg_q[BIT_CLOCK_RATE]    <= strap_s[UP_SOUT_B];
        end
        else
        begin
            if (reg_wr && reg_addr == OFS_CFG_PORT)
                cfg_port_q <= reg_wdata;
            if (reg_wr && reg_addr == OFS_STRAP_CFG)
                strap_cfg_q <= reg_wdata;
        end
    end

    assign config_port_addr_q = cfg_port_q[BIT_CFG_PORT_ADDR];
    assign clear_defaults_q   = strap_cfg_q[BIT_CLEAR_DEFAULTS];
    assign kbd_enable_bit_q   = strap_cfg_q[BIT_KBD_ENABLE];
    assign clock_rate_bit_q   = strap_cfg_q[BIT_CLOCK_RATE];

    // Software control registers
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            pin_sel_a_q   <= RST_PIN_SEL_A;
            pin_sel_b_q   <= RST_PIN_SEL_B;
            modem_ctl_a_q <= RST_MODEM_CTL;
            modem_ctl_b_q <= RST_MODEM_CTL;
            pm_ctl_q      <= RST_PM_CTL;
            gpio2_data_q  <= RST_GPIO2;
            gpio2_dir_q   <= RST_GPIO2;
            gpio2_alt_q   <= RST_GPIO2;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                OFS_PIN_SEL_A:  pin_sel_a_q   <= reg_wdata;
                OFS_PIN_SEL_B:  pin_sel_b_q   <= reg_wdata;
                OFS_MODEM_CTLA: modem_ctl_a_q <= reg_wdata;
                OFS_MODEM_CTLB: modem_ctl_b_q <= reg_wdata;
                OFS_PM_CTL:     pm_ctl_q      <= reg_wdata;
                OFS_GPIO2_DATA: gpio2_data_q  <= reg_wdata[5:0];
                OFS_GPIO2_DIR:  gpio2_dir_q   <= reg_wdata[5:0];
                OFS_GPIO2_ALT:  gpio2_alt_q   <= reg_wdata[5:0];
                default:        pm_ctl_q      <= pm_ctl_q;
            endcase
        end
    end

    // Read mux; modem bits report the asserted (low) state as one
    always_comb
    begin
        rdata_d = 8'h00;
        unique case (reg_addr)
            OFS_STRAP_CFG:  rdata_d = strap_cfg_q;
            OFS_CFG_PORT:   rdata_d = cfg_port_q;
            OFS_PIN_SEL_A:  rdata_d = pin_sel_a_q;
            OFS_PIN_SEL_B:  rdata_d = pin_sel_b_q;
            OFS_HS_STAT_A:  rdata_d = {~dcd_s[0], ~ri_s[0], ~dsr_s[0], ~cts_s[0], 4'h0};
            OFS_HS_STAT_B:  rdata_d = {~dcd_s[1], ~ri_s[1], ~dsr_s[1], ~cts_s[1], 4'h0};
            OFS_MODEM_CTLA: rdata_d = modem_ctl_a_q;
            OFS_MODEM_CTLB: rdata_d = modem_ctl_b_q;
            OFS_GPIO2_DATA: rdata_d = {2'h0, mux_s};
            OFS_GPIO2_DIR:  rdata_d = {2'h0, gpio2_dir_q};
            OFS_GPIO2_ALT:  rdata_d = {2'h0, gpio2_alt_q};
            OFS_PM_CTL:     rdata_d = pm_ctl_q;
            default:        rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            reg_rdata_q <= 8'h00;
        else if (reg_rd)
            reg_rdata_q <= rdata_d;
        else
            reg_rdata_q <= 8'h00;
    end

    a_smi_pm_drive: assert property (@(posedge mclk) disable iff (srst)
        (sel70 == SEL_00 && pm_ctl_q[PM_LEGACY] && pm_event) |=> (mux_pin_oe_q[PIN70] && !mux_pin_out_q[PIN70]))
        else $error("interrupt pin not driven low on power event");

    a_pin70_kbc16: assert property (@(posedge mclk) disable iff (srst)
        (sel70 == SEL_10) |=> (mux_pin_oe_q[PIN70] == !$past(kbd_ctrl_port_drive[KP16])))
        else $error("pin 70 does not follow keyboard port bit 16");

    a_pin72_panel: assert property (@(posedge mclk) disable iff (srst)
        (!pin_sel_b_q[FLD_P72]) |=> (mux_pin_oe_q[PIN72] == $past(panel_switch_output) && !mux_pin_out_q[PIN72]))
        else $error("pin 72 panel switch output wrong");

    a_pin73_input: assert property (@(posedge mclk) disable iff (srst)
        (sel73 == SEL_00) |=> (!mux_pin_oe_q[PIN73] && panel_switch_input_q == $past(mux_s[PIN73])))
        else $error("pin 73 not an input for panel switch");

    a_pin40_cir: assert property (@(posedge mclk) disable iff (srst)
        (sel40 == SEL_00) |=> (!mux_pin_oe_q[PIN40] && consumer_ir_receive_q == $past(mux_s[PIN40])))
        else $error("pin 40 consumer IR path wrong");

    a_pin39_irsel: assert property (@(posedge mclk) disable iff (srst)
        (sel39 == SEL_01) |=> (mux_pin_oe_q[PIN39] && mux_pin_out_q[PIN39] == $past(ir_module_select0)))
        else $error("pin 39 IR select not driven");

    a_pin69_kbreset: assert property (@(posedge mclk) disable iff (srst)
        (gpio2_alt_q[PIN69]) |=> (mux_pin_oe_q[PIN69] == !$past(kbd_ctrl_port_drive[KP20])))
        else $error("pin 69 keyboard reset not following port bit 20");

    a_cts_status_read: assert property (@(posedge mclk) disable iff (srst)
        (reg_rd && reg_addr == OFS_HS_STAT_A) |=> (reg_rdata_q[HS_CTS] == !$past(cts_s[0])))
        else $error("clear-to-send status bit wrong");

    a_rts_dtr_drive: assert property (@(posedge mclk) disable iff (srst)
        (modem_ctl_a_q[MCTL_RTS] && modem_ctl_b_q[MCTL_DTR]) |=>
        (!uart_pin_out_q[UP_RTS_A] && uart_pin_oe_q[UP_RTS_A] && !uart_pin_out_q[UP_DTR_B]))
        else $error("ready modem outputs not driven low");

    a_strap_cfg_port: assert property (@(posedge mclk)
        (srst ##1 !srst) |-> (config_port_addr_q == $past(strap_s[UP_RTS_A])))
        else $error("config port strap not latched");

    a_strap_kbd_clk: assert property (@(posedge mclk)
        (srst ##1 !srst) |-> (kbd_enable_bit_q == $past(strap_s[UP_SOUT_A])
                              && clock_rate_bit_q == $past(strap_s[UP_SOUT_B])))
        else $error("keyboard or clock strap not latched");

    a_strap_float: assert property (@(posedge mclk)
        srst |=> (uart_pin_oe_q[3:0] == 4'h0 && strap_pulldown_q == 4'hf))
        else $error("strap pins driven during reset");

endmodule

// file: src/gpm_pkg.sv
// Constants shared by the pin-function multiplexer and its synchroniser.
// Assumes an 8-bit register address and 8-bit register data on a plain strobe port.
package gpm_pkg;

    // Register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OFS_STRAP_CFG  = 8'h24;
    localparam logic [7:0] OFS_CFG_PORT   = 8'h26;
    localparam logic [7:0] OFS_PIN_SEL_A  = 8'h2a;
    localparam logic [7:0] OFS_PIN_SEL_B  = 8'h2b;
    localparam logic [7:0] OFS_HS_STAT_A  = 8'h30;
    localparam logic [7:0] OFS_HS_STAT_B  = 8'h31;
    localparam logic [7:0] OFS_MODEM_CTLA = 8'h32;
    localparam logic [7:0] OFS_MODEM_CTLB = 8'h33;
    localparam logic [7:0] OFS_GPIO2_DATA = 8'h34;
    localparam logic [7:0] OFS_GPIO2_DIR  = 8'h35;
    localparam logic [7:0] OFS_GPIO2_ALT  = 8'h36;
    localparam logic [7:0] OFS_PM_CTL     = 8'h37;

    // Values after reset
    localparam logic [7:0] RST_PIN_SEL_A  = 8'h00;
    localparam logic [7:0] RST_PIN_SEL_B  = 8'h00;
    localparam logic [7:0] RST_MODEM_CTL  = 8'h00;
    localparam logic [5:0] RST_GPIO2      = 6'h00;
    localparam logic [7:0] RST_PM_CTL     = 8'h01;

    // Field positions in pin_select_reg_b
    localparam int FLD_P70_LO = 3;
    localparam int FLD_P72    = 5;
    localparam int FLD_P73_LO = 6;
    // Field positions in pin_select_reg_a
    localparam int FLD_P40_LO = 4;
    localparam int FLD_P39_LO = 2;

    // Two-bit selection codes
    localparam logic [1:0] SEL_00 = 2'b00;
    localparam logic [1:0] SEL_01 = 2'b01;
    localparam logic [1:0] SEL_10 = 2'b10;

    // Strap bits
    localparam int BIT_CFG_PORT_ADDR = 6;
    localparam int BIT_CLEAR_DEFAULTS = 0;
    localparam int BIT_KBD_ENABLE    = 2;
    localparam int BIT_CLOCK_RATE    = 6;

    // Handshake status bits
    localparam int HS_CTS = 4;
    localparam int HS_DSR = 5;
    localparam int HS_RI  = 6;
    localparam int HS_DCD = 7;

    // Modem control bits
    localparam int MCTL_DTR = 0;
    localparam int MCTL_RTS = 1;

    // Power management control bits
    localparam int PM_LEGACY = 0;

    // Shared pin indices (also the gpio2 bit carried by each pin)
    localparam int PIN69 = 0;
    localparam int PIN70 = 1;
    localparam int PIN72 = 2;
    localparam int PIN73 = 3;
    localparam int PIN40 = 4;
    localparam int PIN39 = 5;

    // Keyboard controller port bit indices
    localparam int KP13 = 0;
    localparam int KP14 = 1;
    localparam int KP15 = 2;
    localparam int KP16 = 3;
    localparam int KP20 = 4;
    localparam int KP21 = 5;

    // UART pin indices; the first four are strap pins
    localparam int UP_RTS_A  = 0;
    localparam int UP_DTR_A  = 1;
    localparam int UP_SOUT_A = 2;
    localparam int UP_SOUT_B = 3;
    localparam int UP_RTS_B  = 4;
    localparam int UP_DTR_B  = 5;

    // Synchronised input vector width
    localparam int SYNC_W = 18;

endpackage

// file: src/gpm_sync_if.sv
// Carries raw pin levels into the synchroniser and the synchronised levels back.
// Assumes one clock shared by both ends.
interface gpm_sync_if #(parameter int W = 1) (input wire logic clk);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport drv (input clk, output raw, input synced);
    modport syn (input clk, input raw, output synced);
endinterface

// file: src/gpm_sync.sv
// Two-flop synchroniser for a vector of pin levels.
// Assumes inputs are asynchronous to clk; no reset so it keeps sampling during reset.
module gpm_sync
    import gpm_pkg::*;
(
    // Pin levels in, synchronised levels out
    gpm_sync_if.syn sif
);
    localparam int W = $bits(sif.raw);

    logic [W-1:0] meta_q;

    always_ff @(posedge sif.clk)
    begin
        meta_q     <= sif.raw;
        sif.synced <= meta_q;
    end
endmodule

// file: dv/gpm_board.sv
// Board model: strap resistors on the UART pins and the modem's control lines.
// Assumes a strap pin is driven only while its output enable is high.
module gpm_board
#(
    parameter logic [3:0] PULLUP = 4'b1010
)
(
    // Strap pins
    input  wire logic [5:0] uart_pin_out_q,
    input  wire logic [5:0] uart_pin_oe_q,
    input  wire logic [3:0] strap_pulldown_q,
    output logic      [3:0] strap_pin_in,
    // Modem state, high = asserted
    input  wire logic [1:0] cts,
    input  wire logic [1:0] dsr,
    input  wire logic [1:0] dcd,
    input  wire logic [1:0] ri,
    output logic      [1:0] clear_to_send_n,
    output logic      [1:0] data_set_ready_n,
    output logic      [1:0] carrier_detect_n,
    output logic      [1:0] ring_indicator_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] oe;
    logic [3:0] dv;
    assign oe = uart_pin_oe_q[3:0];
    assign dv = uart_pin_out_q[3:0];
    // Pull-up wins over the weak pull-down; with the pull-down off, a floating pin without pull-up flips its last level
    assign strap_pin_in = (oe & dv) | (~oe & (PULLUP | (~strap_pulldown_q & ~dv)));
    assign clear_to_send_n  = ~cts;
    assign data_set_ready_n = ~dsr;
    assign carrier_detect_n = ~dcd;
    assign ring_indicator_n = ~ri;
endmodule

// file: dv/tb_top.sv
// Testbench for the pin multiplexer: register tasks, pin stimulus and strap checks.
// Assumes the board model supplies strap levels and modem lines.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import gpm_pkg::*;
    logic       mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata_q;
    logic [5:0] mux_pin_in, mux_pin_out_q, mux_pin_oe_q, pin_ext = 6'h3f;
    logic [3:0] strap_pin_in, strap_pulldown_q;
    logic [5:0] uart_pin_out_q, uart_pin_oe_q, kbd_ctrl_port_sense_q, kbd_ctrl_port_drive = 6'h3f;
    logic [1:0] clear_to_send_n, data_set_ready_n, carrier_detect_n, ring_indicator_n;
    logic [1:0] uart_serial_out = 2'h3, cts = 0, dsr = 0, dcd = 0, ri = 0;
    logic       pm_event = 0, panel_switch_output = 0, ir_module_select0 = 0;
    logic       consumer_ir_receive_q, fast_ir_receive_q, panel_switch_input_q;
    logic       config_port_addr_q, clear_defaults_q, kbd_enable_bit_q, clock_rate_bit_q;
    int         fails = 0, compares = 0;

    always #50 mclk = ~mclk;
    assign mux_pin_in = (mux_pin_oe_q & mux_pin_out_q) | (~mux_pin_oe_q & pin_ext);

    gpm_pin_mux dut (.*);
    gpm_board board (.uart_pin_out_q(uart_pin_out_q), .uart_pin_oe_q(uart_pin_oe_q),
        .strap_pulldown_q(strap_pulldown_q), .strap_pin_in(strap_pin_in), .cts(cts), .dsr(dsr),
        .dcd(dcd), .ri(ri), .clear_to_send_n(clear_to_send_n), .data_set_ready_n(data_set_ready_n),
        .carrier_detect_n(carrier_detect_n), .ring_indicator_n(ring_indicator_n));

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk("rdata", exp, reg_rdata_q & m);
    endtask

    task automatic settle();
        repeat (4) @(posedge mclk);
        #1;
    endtask

    task automatic finish_test();
        if (fails == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge mclk);
        fails++;
        finish_test();
    end

    initial
    begin
        repeat (12) @(posedge mclk);
        #1;
        chk("pulldown", 8'h0f, {4'h0, strap_pulldown_q});
        srst <= 1'b0;
        @(posedge mclk);
        #1;
        chk("uart_oe", 8'h3f, {2'h0, uart_pin_oe_q});
        chk("straps", 8'h05, {4'h0, config_port_addr_q, clear_defaults_q, kbd_enable_bit_q, clock_rate_bit_q});
        rd(OFS_STRAP_CFG, 8'h45, 8'h41);
        rd(OFS_CFG_PORT, 8'h40, 8'h00);
        rd(8'h7f, 8'hff, 8'h00);
        pm_event <= 1'b1;
        panel_switch_output <= 1'b1;
        pin_ext <= 6'h07;
        cts <= 2'b01;
        dsr <= 2'b01;
        dcd <= 2'b01;
        ri <= 2'b01;
        settle();
        chk("pin70", 8'h02, {6'h0, mux_pin_oe_q[1], mux_pin_out_q[1]});
        chk("pin72", 8'h02, {6'h0, mux_pin_oe_q[2], mux_pin_out_q[2]});
        chk("panel_in", 8'h00, {7'h0, panel_switch_input_q});
        chk("fir", 8'h00, {7'h0, fast_ir_receive_q});
        rd(OFS_HS_STAT_A, 8'hf0, 8'hf0);
        rd(OFS_HS_STAT_B, 8'hff, 8'h00);
        chk("rts_dtr", 8'h03, {6'h0, uart_pin_out_q[1:0]});
        wr(OFS_MODEM_CTLA, 8'h03);
        settle();
        chk("rts_dtr", 8'h00, {6'h0, uart_pin_out_q[1:0]});
        pm_event <= 1'b0;
        settle();
        chk("pin70", 8'h00, {7'h0, mux_pin_oe_q[1]});
        wr(OFS_PIN_SEL_B, 8'h30);
        wr(OFS_GPIO2_DIR, 8'h05);
        wr(OFS_GPIO2_DATA, 8'h05);
        wr(OFS_PIN_SEL_A, 8'h04);
        ir_module_select0 <= 1'b1;
        kbd_ctrl_port_drive[KP16] <= 1'b0;
        settle();
        chk("pin70", 8'h02, {6'h0, mux_pin_oe_q[1], mux_pin_out_q[1]});
        chk("sense16", 8'h00, {7'h0, kbd_ctrl_port_sense_q[KP16]});
        chk("pin72", 8'h03, {6'h0, mux_pin_oe_q[2], mux_pin_out_q[2]});
        chk("pin69", 8'h03, {6'h0, mux_pin_oe_q[0], mux_pin_out_q[0]});
        chk("pin39", 8'h03, {6'h0, mux_pin_oe_q[5], mux_pin_out_q[5]});
        chk("cir", 8'h00, {7'h0, consumer_ir_receive_q});
        wr(OFS_MODEM_CTLB, 8'h01);
        wr(OFS_GPIO2_ALT, 8'h01);
        wr(OFS_PIN_SEL_A, 8'h28);
        kbd_ctrl_port_drive[KP20] <= 1'b0;
        uart_serial_out <= 2'b01;
        settle();
        chk("uart_b", 8'h05, {4'h0, uart_pin_out_q[5:2]});
        chk("pin69", 8'h02, {6'h0, mux_pin_oe_q[0], mux_pin_out_q[0]});
        chk("sense20", 8'h00, {7'h0, kbd_ctrl_port_sense_q[KP20]});
        chk("sense13", 8'h00, {7'h0, kbd_ctrl_port_sense_q[KP13]});
        chk("fir", 8'h01, {7'h0, fast_ir_receive_q});
        rd(OFS_GPIO2_DATA, 8'h3f, 8'h04);
        wr(OFS_STRAP_CFG, 8'h04);
        rd(OFS_STRAP_CFG, 8'h45, 8'h04);
        chk("kbd_en", 8'h01, {7'h0, kbd_enable_bit_q});
        finish_test();
    end
endmodule
